// ### include/sector_ecc_pkg.sv
/*
  Constants and types for the sector check engine: polynomials, field
  lengths, operation codes and state codes.
  Assumes one synchronous clock domain shared by every user of it.
*/
package sector_ecc_pkg;
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [31:0] ECC_POLY       = 32'h140a0445;
  localparam logic [31:0] ECC_RECIP      = 32'h4440a051;
  localparam logic [31:0] ECC_INIT       = 32'h00000000;
  localparam int          ID_BYTES       = 6;
  localparam int          DATA_BYTES     = 512;
  localparam int          ECC_BYTES      = 4;
  localparam int          BURST_BITS     = 11;
  localparam int          SEARCH_STEPS   = (DATA_BYTES + ECC_BYTES) * 8 + 32;
  localparam int          MAX_RETRIES    = 8;

  typedef enum logic [1:0] {
    OP_ID    = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10
  } op_kind_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_ID     = 3'b001,
    S_DATA   = 3'b010,
    S_APPEND = 3'b011,
    S_SEARCH = 3'b100,
    S_DONE   = 3'b101
  } state_t;
endpackage : sector_ecc_pkg

// ### hdl/sector_ecc.sv
/*
  Sector check engine: CRC check of ID fields, 32-bit code generation
  and checking of data fields, burst trapping for correction, retry control.
  Assumes the byte stream arrives MSB first from same-clock logic, and that
  the sector buffer applies the reported burst fix itself.
*/
`timescale 1ns/1ps
`default_nettype none
module sector_ecc #(
  parameter int SEARCH_LIMIT = sector_ecc_pkg::SEARCH_STEPS,
  parameter int RETRY_LIMIT  = sector_ecc_pkg::MAX_RETRIES
) (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic                     op_start,
  input  wire sector_ecc_pkg::op_kind_t op_kind,
  input  wire logic                     op_long,
  input  wire logic                     retry_enable,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [7:0]               in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [7:0]                    out_data,
  output logic                          busy,
  output logic                          op_done,
  output logic                          op_failed,
  output logic                          retry_req,
  output logic                          id_error,
  output logic                          data_error,
  output logic                          burst_fixable,
  output logic                          burst_unfixable,
  output logic [10:0]                   burst_pattern,
  output logic [12:0]                   burst_shift
);
  import sector_ecc_pkg::*;

  // byte-wide CRC step, MSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] r, input logic [7:0] d);
    logic [15:0] c;
    c = r;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc_byte

  // byte-wide data code step, MSB first
  function automatic logic [31:0] ecc_byte(input logic [31:0] r, input logic [7:0] d);
    logic [31:0] c;
    c = r;
    for (int i = 7; i >= 0; i--) begin
      c = (c[31] ^ d[i]) ? ({c[30:0], 1'b0} ^ ECC_POLY) : {c[30:0], 1'b0};
    end
    return c;
  endfunction : ecc_byte

  function automatic logic [31:0] bitrev32(input logic [31:0] v);
    logic [31:0] o;
    o = '0;
    for (int i = 0; i < 32; i++) begin
      o[i] = v[31-i];
    end
    return o;
  endfunction : bitrev32

  localparam logic [9:0]  ID_LAST   = 10'(ID_BYTES - 1);
  localparam logic [9:0]  DATA_LAST = 10'(DATA_BYTES - 1);
  localparam logic [9:0]  FULL_LAST = 10'(DATA_BYTES + ECC_BYTES - 1);
  localparam logic [9:0]  DATA_LEN  = 10'(DATA_BYTES);
  localparam logic [9:0]  ECC_LAST  = 10'(ECC_BYTES - 1);
  localparam logic [12:0] SRCH_LAST = 13'(SEARCH_LIMIT - 1);
  localparam logic [3:0]  RETRY_MAX = 4'(RETRY_LIMIT);

  state_t      state_ff;
  op_kind_t    kind_ff;
  logic        long_ff;
  logic [9:0]  cnt_ff;
  logic [15:0] crc_ff;
  logic [31:0] ecc_ff;
  logic [31:0] trap_ff;
  logic [12:0] step_ff;
  logic [3:0]  tries_ff;
  logic        err_any;

  // two-entry buffer toward the receiver
  logic [7:0]  buf_mem [2];
  logic        buf_wp_ff;
  logic        buf_rp_ff;
  logic [1:0]  buf_cnt_ff;
  logic        buf_in_ready;
  logic        push;
  logic [7:0]  push_data;
  logic        pop;
  logic        fwd;
  logic        take;
  logic        last_in;
  logic [15:0] nxt_crc;
  logic [31:0] nxt_ecc;
  logic        trapped;
  logic [31:0] trap_rev;

  // forwarding and acceptance; a full buffer stalls only input bytes that are forwarded
  always_comb begin
    fwd = (kind_ff == OP_WRITE) || long_ff || (cnt_ff < DATA_LEN);
    in_ready = (state_ff == S_ID) || ((state_ff == S_DATA) && (!fwd || buf_in_ready));
    take = in_valid && in_ready;
    nxt_crc = crc_byte(crc_ff, in_data);
    nxt_ecc = ecc_byte(ecc_ff, in_data);
    if (state_ff == S_ID) begin
      last_in = (cnt_ff == ID_LAST);
    end else if ((kind_ff == OP_WRITE) && !long_ff) begin
      last_in = (cnt_ff == DATA_LAST);
    end else begin
      last_in = (cnt_ff == FULL_LAST);
    end
    push = (take && fwd && (state_ff == S_DATA)) || ((state_ff == S_APPEND) && buf_in_ready);
    push_data = (state_ff == S_APPEND) ? ecc_ff[31:24] : in_data;
    // burst confined to the top 11 bits (low 21 bits clear)
    trapped = (trap_ff[20:0] == 21'h000000);
    // un-reversed trap: a caught burst sits in bits 10:0, lowest power at bit 0
    trap_rev = bitrev32(trap_ff);
    err_any = id_error || data_error;
  end

  assign buf_in_ready = (buf_cnt_ff != 2'd2);
  assign out_valid    = (buf_cnt_ff != 2'd0);
  assign out_data     = buf_mem[buf_rp_ff];
  assign pop          = out_valid && out_ready;
  assign busy         = (state_ff != S_IDLE);

  // buffer pointers and occupancy
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      buf_wp_ff  <= 1'b0;
      buf_rp_ff  <= 1'b0;
      buf_cnt_ff <= 2'd0;
    end else begin
      if (push) begin
        buf_wp_ff <= ~buf_wp_ff;
      end
      if (pop) begin
        buf_rp_ff <= ~buf_rp_ff;
      end
      buf_cnt_ff <= 2'(buf_cnt_ff + {1'b0, push} - {1'b0, pop});
    end
  end

  // buffer storage, no reset needed since reads are gated by out_valid
  always_ff @(posedge clock) begin
    if (push) begin
      buf_mem[buf_wp_ff] <= push_data;
    end
  end

  // sequencing of one field
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= S_IDLE;
      kind_ff  <= OP_ID;
      long_ff  <= 1'b0;
      cnt_ff   <= 10'h000;
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (op_start) begin
            kind_ff  <= op_kind;
            long_ff  <= op_long;
            cnt_ff   <= 10'h000;
            state_ff <= (op_kind == OP_ID) ? S_ID : S_DATA;
          end
        end
        S_ID: begin
          if (take) begin
            cnt_ff <= cnt_ff + 10'h001;
            if (last_in) begin
              state_ff <= S_DONE;
            end
          end
        end
        S_DATA: begin
          if (take) begin
            cnt_ff <= last_in ? 10'h000 : cnt_ff + 10'h001;
            if (last_in) begin
              if (kind_ff == OP_WRITE) begin
                state_ff <= long_ff ? S_DONE : S_APPEND;
              end else if (!long_ff && (nxt_ecc != 32'h00000000)) begin
                state_ff <= S_SEARCH;
              end else begin
                state_ff <= S_DONE;
              end
            end
          end
        end
        S_APPEND: begin
          if (buf_in_ready) begin
            cnt_ff <= cnt_ff + 10'h001;
            if (cnt_ff == ECC_LAST) begin
              state_ff <= S_DONE;
            end
          end
        end
        S_SEARCH: begin
          if (trapped || (step_ff == SRCH_LAST)) begin
            state_ff <= S_DONE;
          end
        end
        S_DONE: begin
          state_ff <= S_IDLE;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // check registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      crc_ff <= CRC_INIT;
      ecc_ff <= ECC_INIT;
    end else if ((state_ff == S_IDLE) && op_start) begin
      crc_ff <= CRC_INIT;
      ecc_ff <= ECC_INIT;
    end else if (take && (state_ff == S_ID)) begin
      crc_ff <= nxt_crc;
    end else if (take && (state_ff == S_DATA)) begin
      ecc_ff <= nxt_ecc;
    end else if ((state_ff == S_APPEND) && buf_in_ready) begin
      ecc_ff <= {ecc_ff[23:0], 8'h00};
    end
  end

  // burst trapping: stepping the reversed syndrome forward divides by x
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      trap_ff <= 32'h00000000;
      step_ff <= 13'h0000;
    end else if (take && (state_ff == S_DATA) && last_in) begin
      trap_ff <= bitrev32(nxt_ecc);
      step_ff <= 13'h0000;
    end else if ((state_ff == S_SEARCH) && !trapped) begin
      trap_ff <= trap_ff[31] ? ({trap_ff[30:0], 1'b0} ^ ECC_RECIP) : {trap_ff[30:0], 1'b0};
      step_ff <= step_ff + 13'h0001;
    end
  end

  // result flags, cleared when a new operation begins
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      id_error        <= 1'b0;
      data_error      <= 1'b0;
      burst_fixable   <= 1'b0;
      burst_unfixable <= 1'b0;
      burst_pattern   <= 11'h000;
      burst_shift     <= 13'h0000;
    end else if ((state_ff == S_IDLE) && op_start) begin
      id_error        <= 1'b0;
      data_error      <= 1'b0;
      burst_fixable   <= 1'b0;
      burst_unfixable <= 1'b0;
    end else if (take && (state_ff == S_ID) && last_in) begin
      id_error <= (nxt_crc != 16'h0000);
    end else if (take && (state_ff == S_DATA) && last_in && (kind_ff == OP_READ) && !long_ff) begin
      data_error <= (nxt_ecc != 32'h00000000);
    end else if (state_ff == S_SEARCH) begin
      if (trapped) begin
        burst_fixable <= 1'b1;
        burst_pattern <= trap_rev[10:0];
        burst_shift   <= step_ff;
      end else if (step_ff == SRCH_LAST) begin
        burst_unfixable <= 1'b1;
      end
    end
  end

  // completion and retry decision
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      op_done   <= 1'b0;
      op_failed <= 1'b0;
      retry_req <= 1'b0;
      tries_ff  <= 4'h0;
    end else begin
      op_done   <= 1'b0;
      op_failed <= 1'b0;
      retry_req <= 1'b0;
      if (state_ff == S_DONE) begin
        // retry only when the option is on
        if (err_any && retry_enable && (tries_ff < RETRY_MAX)) begin
          retry_req <= 1'b1;
          tries_ff  <= tries_ff + 4'h1;
        end else begin
          op_done   <= 1'b1;
          op_failed <= err_any;
          tries_ff  <= 4'h0;
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence done_with_error;
    (state_ff == S_DONE) && err_any;
  endsequence

  a_id_no_fix: assert property ((kind_ff == OP_ID) |-> !burst_fixable)
    else $error("id field got a correction");
  a_crc_flag: assert property (take && (state_ff == S_ID) && last_in
                               |=> id_error == ($past(nxt_crc) != 16'h0000))
    else $error("id error flag disagrees with crc remainder");
  a_field_len: assert property ((state_ff == S_DATA) && take && last_in && !long_ff
                                && (kind_ff == OP_WRITE) |-> cnt_ff == 10'd511)
    else $error("data field length wrong");
  a_append_byte: assert property ((state_ff == S_APPEND) && buf_in_ready
                                  |-> push && push_data == ecc_ff[31:24])
    else $error("check byte not appended");
  a_retry_on: assert property (done_with_error ##0 retry_enable && (tries_ff < RETRY_MAX)
                               |=> retry_req && !op_done)
    else $error("missing retry");
  a_retry_off: assert property (done_with_error ##0 !retry_enable
                                |=> !retry_req && op_done && op_failed)
    else $error("retry while disabled");
  a_long_raw: assert property (long_ff && busy |-> state_ff != S_APPEND
                               && state_ff != S_SEARCH)
    else $error("long op altered the stream");
  a_fix_source: assert property ($rose(burst_fixable) |-> $past(state_ff) == S_SEARCH
                                 && data_error)
    else $error("fix without data error");
  a_search_end: assert property ((state_ff == S_SEARCH) && (step_ff == SRCH_LAST) && !trapped
                                 |=> burst_unfixable ##1 state_ff == S_IDLE)
    else $error("long burst not reported");
  a_buf_bound: assert property (buf_cnt_ff <= 2'd2 && !(push && !buf_in_ready))
    else $error("buffer overrun");
endmodule : sector_ecc
`default_nettype wire

// ### bench/drive_channel_model.sv
/*
  Drive-side channel model: feeds bytes into the engine and captures the
  forwarded stream, stalling the sink every stall_every cycles.
  Assumes the bench loads src, src_pos and src_len between operations.
*/
`timescale 1ns/1ps
`default_nettype none
module drive_channel_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       in_ready,
  output logic            in_valid,
  output logic [7:0]      in_data,
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic [7:0] out_data
);
  logic [7:0] src [0:515];
  logic [7:0] sink [$];
  int         src_len     = 0;
  int         src_pos     = 0;
  int         stall_every = 0;
  int         tick        = 0;

  // idle data is inverted each cycle so a stale byte never looks valid
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      in_valid  <= 1'b0;
      in_data   <= 8'h00;
      out_ready <= 1'b0;
    end else begin
      if (in_valid && in_ready) src_pos = src_pos + 1;
      if (out_valid && out_ready) sink.push_back(out_data);
      tick = tick + 1;
      out_ready <= (stall_every == 0) || (tick % stall_every != 0);
      in_valid  <= (src_pos < src_len);
      in_data   <= (src_pos < src_len) ? src[src_pos] : ~in_data;
    end
  end
endmodule : drive_channel_model
`default_nettype wire

// ### bench/disk_sector_ecc_crc_bench.sv
/*
  Bench for the sector check engine: ID check, write with appended code,
  long write, clean and damaged reads with retry on and off.
  Assumes the package and the drive channel model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module disk_sector_ecc_crc_bench;
  import sector_ecc_pkg::*;
  logic        clock        = 1'b0;
  logic        sys_rst      = 1'b1;
  logic        op_start     = 1'b0;
  op_kind_t    op_kind      = OP_ID;
  logic        op_long      = 1'b0;
  logic        retry_enable = 1'b0;
  logic        in_valid;
  logic        in_ready;
  logic [7:0]  in_data;
  logic        out_valid;
  logic        out_ready;
  logic [7:0]  out_data;
  logic        busy;
  logic        op_done;
  logic        op_failed;
  logic        retry_req;
  logic        id_error;
  logic        data_error;
  logic        burst_fixable;
  logic        burst_unfixable;
  logic [10:0] burst_pattern;
  logic [12:0] burst_shift;
  logic [7:0]  blk [0:515];
  int          miscompares     = 0;
  int          samples_checked = 0;

  sector_ecc sector_ecc_i (
    .clock(clock), .sys_rst(sys_rst), .op_start(op_start), .op_kind(op_kind),
    .op_long(op_long), .retry_enable(retry_enable), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .busy(busy), .op_done(op_done),
    .op_failed(op_failed), .retry_req(retry_req), .id_error(id_error),
    .data_error(data_error), .burst_fixable(burst_fixable),
    .burst_unfixable(burst_unfixable), .burst_pattern(burst_pattern),
    .burst_shift(burst_shift));

  drive_channel_model drive_channel_model_i (
    .clock(clock), .sys_rst(sys_rst), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));

  // 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // bitwise MSB-first shift register over blk, masked to w bits
  function automatic logic [31:0] lfsr(input int n, input int w, input logic [31:0] poly,
                                       input logic [31:0] init);
    logic [31:0] r;
    logic        fb;
    r = init;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--) begin
        fb = r[w-1] ^ blk[i][b];
        r  = (r << 1) ^ (fb ? poly : 32'h00000000);
      end
    return r & ((32'h00000001 << w) - 32'h00000001);
  endfunction : lfsr

  // count of captured bytes that differ from blk, plus one for a bad size
  function automatic int sink_bad(input int n);
    int bad;
    bad = (drive_channel_model_i.sink.size() != n) ? 1 : 0;
    for (int i = 0; i < n && i < drive_channel_model_i.sink.size(); i++)
      if (drive_channel_model_i.sink[i] !== blk[i]) bad++;
    return bad;
  endfunction : sink_bad

  // data is loaded only once busy is up, so no byte can slip in early
  task automatic run_op(input op_kind_t k, input logic lng, input logic rty, input int n,
                        input int stall, output logic [2:0] res);
    int w;
    drive_channel_model_i.sink.delete();
    drive_channel_model_i.stall_every = stall;
    @(posedge clock);
    op_start     <= 1'b1;
    op_kind      <= k;
    op_long      <= lng;
    retry_enable <= rty;
    @(posedge clock);
    op_start <= 1'b0;
    @(negedge clock);
    for (int i = 0; i < n; i++) drive_channel_model_i.src[i] = blk[i];
    drive_channel_model_i.src_pos = 0;
    drive_channel_model_i.src_len = n;
    w = 0;
    while (op_done !== 1'b1 && retry_req !== 1'b1 && w < 20000) begin
      @(negedge clock);
      w++;
    end
    res = {op_done, retry_req, op_failed};
    if (w >= 20000) miscompares++;
    w = 0;
    while (out_valid === 1'b1 && w < 50) begin
      @(negedge clock);
      w++;
    end
  endtask : run_op

  task automatic sc_id();
    logic [2:0]  r;
    logic [15:0] c;
    for (int bad = 0; bad < 2; bad++) begin
      for (int i = 0; i < 4; i++) blk[i] = 8'h3c + 8'(i * 17);
      c = 16'(lfsr(4, 16, 32'h00001021, 32'(CRC_INIT)));
      blk[4] = c[15:8];
      blk[5] = c[7:0] ^ 8'(bad);
      run_op(OP_ID, 1'b0, 1'b0, ID_BYTES, 0, r);
      check({r, id_error, burst_fixable, busy}, {3'b100 | 3'(bad), bad[0], 2'b00});
    end
  endtask : sc_id

  task automatic sc_write();
    logic [2:0]  r;
    logic [31:0] e;
    for (int i = 0; i < DATA_BYTES; i++) blk[i] = 8'(i * 7) ^ 8'ha5;
    e = lfsr(DATA_BYTES, 32, 32'h140a0445, ECC_INIT);
    for (int i = 0; i < ECC_BYTES; i++) blk[DATA_BYTES + i] = e[31 - 8 * i -: 8];
    run_op(OP_WRITE, 1'b0, 1'b0, DATA_BYTES, 3, r);
    check(sink_bad(DATA_BYTES + ECC_BYTES), 0);
    check(r, 3'b100);
    blk[514] = ~blk[514];
    run_op(OP_WRITE, 1'b1, 1'b0, DATA_BYTES + ECC_BYTES, 2, r);
    check(sink_bad(DATA_BYTES + ECC_BYTES), 0);
    blk[514] = ~blk[514];
  endtask : sc_write

  task automatic sc_read();
    logic [2:0] r;
    run_op(OP_READ, 1'b0, 1'b0, DATA_BYTES + ECC_BYTES, 4, r);
    check(sink_bad(DATA_BYTES), 0);
    check({r, data_error}, 4'b1000);
    blk[511] = blk[511] ^ 8'h07;
    for (int rty = 1; rty >= 0; rty--) begin
      run_op(OP_READ, 1'b0, rty[0], DATA_BYTES + ECC_BYTES, 0, r);
      check({r, data_error, burst_fixable, burst_unfixable},
            {~rty[0], rty[0], ~rty[0], 3'b110});
      // the trap fires as soon as the whole burst fits the 11-bit window, so the
      // pattern comes out left-justified: bits 32..34 show as 0x700 at step 56
      check({burst_pattern, burst_shift}, {11'h700, 13'h0038});
    end
    // long read of the damaged field: all bytes raw, no flags, so no retry either
    run_op(OP_READ, 1'b1, 1'b1, DATA_BYTES + ECC_BYTES, 2, r);
    check(sink_bad(DATA_BYTES + ECC_BYTES), 0);
    check({r, data_error, burst_fixable, burst_unfixable}, 6'b100000);
    blk[511] = blk[511] ^ 8'h06;
    blk[510] = blk[510] ^ 8'h80;
    run_op(OP_READ, 1'b0, 1'b0, DATA_BYTES + ECC_BYTES, 0, r);
    check({r, burst_fixable, burst_unfixable}, 5'b10101);
  endtask : sc_read

  // runs of a few thousand cycles each; 80k cycles means a hang
  initial begin
    #800000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    sc_id();
    sc_write();
    sc_read();
    close_out();
  end
endmodule : disk_sector_ecc_crc_bench
`default_nettype wire
